/* File: logic/wdw_pkg.sv */
// package of the window watchdog for channels 5 and 6: offsets, fields, resets
// assumes an 8-bit register port and 12-bit conversion results
package wdw_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int RES_W = 12;
  localparam int CH_W = 3;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] CH5_UPPER_LIMIT_LSB_AND_DEADBAND = 8'h34;
  localparam logic [7:0] CH5_UPPER_LIMIT_MSB = 8'h35;
  localparam logic [7:0] CH5_LOWER_LIMIT_LSB_AND_TRIP_COUNT = 8'h36;
  localparam logic [7:0] CH5_LOWER_LIMIT_MSB = 8'h37;
  localparam logic [7:0] CH6_UPPER_LIMIT_LSB_AND_DEADBAND = 8'h38;
  localparam logic [7:0] CH6_UPPER_LIMIT_MSB = 8'h39;
  localparam logic [7:0] CH6_LOWER_LIMIT_LSB_AND_TRIP_COUNT = 8'h3a;
  localparam logic [7:0] CH6_LOWER_LIMIT_MSB = 8'h3b;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int NIB_HI_LSB = 4;
  localparam int NIB_LO_LSB = 0;
  localparam int DEADBAND_SHIFT = 3;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] UPPER_MSB_RST = 8'hff;
  localparam logic [7:0] UPPER_LSB_DEADBAND_RST = 8'hf0;
  localparam logic [7:0] LOWER_LSB_TRIP_RST = 8'h00;
  localparam logic [7:0] LOWER_MSB_RST = 8'h00;
endpackage

/* File: logic/wdw_sample_if.sv */
// carrier of conversion results from the top to each channel comparator
// assumes one result per valid cycle, tagged with its channel number
`timescale 1ns/1ns
interface wdw_sample_if;
  logic valid;
  logic [2:0] ch;
  logic [11:0] result;
  modport src (output valid, ch, result);
  modport snk (input valid, ch, result);
endinterface

/* File: logic/wdw_channel.sv */
// one channel of the window comparator with deadband and trip counter
// assumes sample bus and settings synchronous to sys_clk_i
`timescale 1ns/1ns
module wdw_channel
  import wdw_pkg::*;
#(
  parameter logic [2:0] CH_NUM = 3'h5
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // samples
  wdw_sample_if.snk smp,
  // settings
  input wire logic [7:0] upper_msb_i,
  input wire logic [3:0] upper_nib_i,
  input wire logic [7:0] lower_msb_i,
  input wire logic [3:0] lower_nib_i,
  input wire logic [3:0] deadband_i,
  input wire logic [3:0] trip_count_i,
  // alert
  input wire logic alert_clr_i,
  output logic alert_o
);
  logic [12:0] upper;
  logic [12:0] lower;
  logic [12:0] res;
  logic [12:0] band;
  logic mine;
  logic above;
  logic below;
  logic outside;
  logic [3:0] run;
  logic trip;

  // ----------------------------------------
  // window bounds
  // ----------------------------------------
  assign upper = {1'b0, upper_msb_i, upper_nib_i};
  assign lower = {1'b0, lower_msb_i, lower_nib_i};
  assign band = {6'h00, deadband_i, 3'b000};
  assign res = {1'b0, smp.result};
  assign mine = smp.valid && (smp.ch == CH_NUM);
  // deadband pulls both bounds inward once the alert stands
  assign above = alert_o ? (res + band > upper) : (res > upper);
  assign below = alert_o ? (res < lower + band) : (res < lower);
  assign outside = above || below;
  assign trip = mine && outside && (run >= trip_count_i);

  // ----------------------------------------
  // consecutive count
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      run <= 4'h0;
    end else if (mine) begin
      if (!outside) begin
        run <= 4'h0;
      end else if (run < trip_count_i) begin
        run <= run + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // alert flag, set wins over clear
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      alert_o <= 1'b0;
    end else if (trip) begin
      alert_o <= 1'b1;
    end else if (alert_clr_i) begin
      alert_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_out_run;
    mine && outside && !alert_o;
  endsequence

  chk_top_byte_high: assert property (mine && !alert_o && smp.result[11:4] > upper_msb_i |-> outside)
    else $error("result byte above upper byte not flagged");
  chk_low_nibble_high: assert property (mine && !alert_o && smp.result[11:4] == upper_msb_i
      && smp.result[3:0] > upper_nib_i |-> above)
    else $error("upper nibble compare failed");
  chk_low_nibble_low: assert property (mine && !alert_o && smp.result[11:4] == lower_msb_i
      && smp.result[3:0] < lower_nib_i |-> below)
    else $error("lower nibble compare failed");
  chk_top_byte_low: assert property (mine && !alert_o && smp.result[11:4] < lower_msb_i |-> below)
    else $error("result byte below lower byte not flagged");
  chk_deadband_shift: assert property (mine && alert_o && res <= upper
      && res + {6'h00, deadband_i, 3'b000} > upper |-> outside)
    else $error("deadband not applied as shifted by three");
  chk_trip_after_run: assert property (mine && outside && run == trip_count_i |=> alert_o)
    else $error("alert missing after n+1 samples");
  chk_no_early_trip: assert property (s_out_run ##0 (run < trip_count_i) ##0 !alert_clr_i |=> !alert_o)
    else $error("alert raised before n+1 samples");
  chk_run_restart: assert property (mine && !outside |=> run == 4'h0
      && alert_o == ($past(alert_o) && !$past(alert_clr_i)))
    else $error("run not restarted by in-window sample");
endmodule

/* File: logic/wdw_top.sv */
// window watchdog for channels 5 and 6 with its threshold registers
// assumes the serial host port delivers decoded byte reads and writes
`timescale 1ns/1ns
module wdw_top
  import wdw_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // conversion results
  input wire logic res_valid_i,
  input wire logic [2:0] res_ch_i,
  input wire logic [11:0] res_data_i,
  // alerts, index 0 is channel 5
  input wire logic [1:0] alert_clr_i,
  output logic [1:0] alert_o
);
  logic [7:0] upper_lsb_deadband [2];
  logic [7:0] upper_msb [2];
  logic [7:0] lower_lsb_trip [2];
  logic [7:0] lower_msb [2];
  logic [7:0] next_rdata;

  wdw_sample_if smp ();

  assign smp.valid = res_valid_i;
  assign smp.ch = res_ch_i;
  assign smp.result = res_data_i;

  function automatic logic [7:0] base_of(input int k);
    return (k == 0) ? CH5_UPPER_LIMIT_LSB_AND_DEADBAND : CH6_UPPER_LIMIT_LSB_AND_DEADBAND;
  endfunction

  // ----------------------------------------
  // per channel registers and comparators
  // ----------------------------------------
  for (genvar k = 0; k < 2; k++) begin : g_ch
    always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
        upper_lsb_deadband[k] <= UPPER_LSB_DEADBAND_RST;
        upper_msb[k] <= UPPER_MSB_RST;
        lower_lsb_trip[k] <= LOWER_LSB_TRIP_RST;
        lower_msb[k] <= LOWER_MSB_RST;
      end else if (reg_wr_i) begin
        if (reg_addr_i == base_of(k)) begin
          upper_lsb_deadband[k] <= reg_wdata_i;
        end
        if (reg_addr_i == base_of(k) + 8'h01) begin
          upper_msb[k] <= reg_wdata_i;
        end
        if (reg_addr_i == base_of(k) + 8'h02) begin
          lower_lsb_trip[k] <= reg_wdata_i;
        end
        if (reg_addr_i == base_of(k) + 8'h03) begin
          lower_msb[k] <= reg_wdata_i;
        end
      end
    end

    wdw_channel #(
      .CH_NUM((k == 0) ? 3'h5 : 3'h6)
    ) u_ch (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .smp(smp.snk),
      .upper_msb_i(upper_msb[k]),
      .upper_nib_i(upper_lsb_deadband[k][NIB_HI_LSB +: 4]),
      .lower_msb_i(lower_msb[k]),
      .lower_nib_i(lower_lsb_trip[k][NIB_HI_LSB +: 4]),
      .deadband_i(upper_lsb_deadband[k][NIB_LO_LSB +: 4]),
      .trip_count_i(lower_lsb_trip[k][NIB_LO_LSB +: 4]),
      .alert_clr_i(alert_clr_i[k]),
      .alert_o(alert_o[k])
    );
  end

  // ----------------------------------------
  // read back, unmapped reads zero
  // ----------------------------------------
  always_comb begin
    case (reg_addr_i)
      CH5_UPPER_LIMIT_LSB_AND_DEADBAND: next_rdata = upper_lsb_deadband[0];
      CH5_UPPER_LIMIT_MSB: next_rdata = upper_msb[0];
      CH5_LOWER_LIMIT_LSB_AND_TRIP_COUNT: next_rdata = lower_lsb_trip[0];
      CH5_LOWER_LIMIT_MSB: next_rdata = lower_msb[0];
      CH6_UPPER_LIMIT_LSB_AND_DEADBAND: next_rdata = upper_lsb_deadband[1];
      CH6_UPPER_LIMIT_MSB: next_rdata = upper_msb[1];
      CH6_LOWER_LIMIT_LSB_AND_TRIP_COUNT: next_rdata = lower_lsb_trip[1];
      CH6_LOWER_LIMIT_MSB: next_rdata = lower_msb[1];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking

  chk_upper_byte_reset: assert property (!nrst_i |=> upper_msb[0] == 8'hff && upper_msb[1] == 8'hff)
    else $error("upper byte not full scale after reset");
  chk_other_reset: assert property (!nrst_i |=> upper_lsb_deadband[1] == 8'hf0 && lower_lsb_trip[1] == 8'h00
      && lower_msb[0] == 8'h00 && alert_o == 2'b00)
    else $error("reset values wrong");
endmodule

/* File: verif/wdw_host_model.sv */
// host-side model: register port master and conversion result source
// assumes the watchdog samples all inputs on the rising edge of sys_clk_i
`timescale 1ns/1ns
module wdw_host_model (
  // clock
  input wire logic sys_clk_i,
  // register port
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  // samples and alert clear
  output logic res_valid_o,
  output logic [2:0] res_ch_o,
  output logic [11:0] res_data_o,
  output logic [1:0] alert_clr_o
);
  // ----------------------------------------
  // idle levels, released address and data lines show inverse data, res_ch_o keeps its channel
  // ----------------------------------------
  initial begin
    {reg_addr_o, reg_wr_o, reg_wdata_o, reg_rd_o} = '0;
    {res_valid_o, res_ch_o, res_data_o, alert_clr_o} = '0;
  end
  // ----------------------------------------
  // transfers, one strobe cycle each
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask
  task automatic smp(input logic [2:0] c, input logic [11:0] v, input logic [1:0] clr);
    @(negedge sys_clk_i);
    res_valid_o = 1'b1;
    res_ch_o = c;
    res_data_o = v;
    alert_clr_o = clr;
    @(negedge sys_clk_i);
    res_valid_o = 1'b0;
    res_data_o = ~v;
    alert_clr_o = 2'b00;
  endtask
endmodule

/* File: verif/tb_top.sv */
// testbench of the window watchdog: register reset values, windows, runs, deadband
// assumes the host model drives every input of wdw_top except sys_clk_i and nrst_i, which the testbench drives
`timescale 1ns/1ns
module tb_top;
  import wdw_pkg::*;
  logic sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, res_valid_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
  logic [2:0] res_ch_i;
  logic [11:0] res_data_i;
  logic [1:0] alert_clr_i, alert_o;
  int n_errors, cmp_count, cycles;
  logic [7:0] rst_tab [8] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'hf0, 8'hff, 8'h00, 8'h00};
  wdw_top wdw_top_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .res_valid_i(res_valid_i), .res_ch_i(res_ch_i), .res_data_i(res_data_i),
    .alert_clr_i(alert_clr_i), .alert_o(alert_o));
  wdw_host_model wdw_host_model_inst (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr_i),
    .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
    .res_valid_o(res_valid_i), .res_ch_o(res_ch_i), .res_data_o(res_data_i), .alert_clr_o(alert_clr_i));
  // ----------------------------------------
  // clock, timeout, checks
  // ----------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    wdw_host_model_inst.rd(a, rv);
    cmp({4'h0, rv}, {4'h0, e});
  endtask
  task automatic alert_chk(input logic [1:0] e);
    @(negedge sys_clk_i);
    cmp({10'h000, alert_o}, {10'h000, e});
  endtask
  task automatic complete_run();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst_i = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (3) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    alert_chk(2'b00);
    for (int i = 0; i < 8; i++) begin
      rd_chk(CH5_UPPER_LIMIT_LSB_AND_DEADBAND + 8'(i), rst_tab[i]);
    end
    wdw_host_model_inst.wr(8'h40, 8'h55);
    rd_chk(8'h40, 8'h00);
    // ch5 window 0x103..0x805, trip count 2
    wdw_host_model_inst.wr(CH5_UPPER_LIMIT_MSB, 8'h80);
    wdw_host_model_inst.wr(CH5_UPPER_LIMIT_LSB_AND_DEADBAND, 8'h50);
    wdw_host_model_inst.wr(CH5_LOWER_LIMIT_MSB, 8'h10);
    wdw_host_model_inst.wr(CH5_LOWER_LIMIT_LSB_AND_TRIP_COUNT, 8'h32);
    rd_chk(CH5_UPPER_LIMIT_MSB, 8'h80);
    rd_chk(CH5_LOWER_LIMIT_LSB_AND_TRIP_COUNT, 8'h32);
    wdw_host_model_inst.smp(3'h5, 12'h806, 2'b00);
    wdw_host_model_inst.smp(3'h6, 12'hfff, 2'b00);
    wdw_host_model_inst.smp(3'h5, 12'h806, 2'b00);
    wdw_host_model_inst.smp(3'h5, 12'h7ff, 2'b00);
    alert_chk(2'b00);
    wdw_host_model_inst.smp(3'h5, 12'h806, 2'b00);
    wdw_host_model_inst.smp(3'h5, 12'h805, 2'b00);
    wdw_host_model_inst.smp(3'h5, 12'h806, 2'b00);
    wdw_host_model_inst.smp(3'h5, 12'h806, 2'b00);
    alert_chk(2'b00);
    wdw_host_model_inst.smp(3'h5, 12'h806, 2'b00);
    alert_chk(2'b01);
    wdw_host_model_inst.smp(3'h0, 12'h000, 2'b01);
    alert_chk(2'b00);
    // ch6 lower bound 0x204, trip count 0, deadband 2
    wdw_host_model_inst.wr(CH6_LOWER_LIMIT_MSB, 8'h20);
    wdw_host_model_inst.wr(CH6_LOWER_LIMIT_LSB_AND_TRIP_COUNT, 8'h40);
    wdw_host_model_inst.wr(CH6_UPPER_LIMIT_LSB_AND_DEADBAND, 8'hf2);
    wdw_host_model_inst.smp(3'h6, 12'h204, 2'b00);
    wdw_host_model_inst.smp(3'h6, 12'h20f, 2'b00);
    alert_chk(2'b00);
    wdw_host_model_inst.smp(3'h6, 12'h1ff, 2'b00);
    alert_chk(2'b10);
    wdw_host_model_inst.smp(3'h6, 12'h210, 2'b10);
    alert_chk(2'b10);
    wdw_host_model_inst.smp(3'h6, 12'h215, 2'b10);
    alert_chk(2'b00);
    wdw_host_model_inst.smp(3'h6, 12'h203, 2'b00);
    alert_chk(2'b10);
    // ch5 upper deadband 1, run of outside samples still unbroken
    wdw_host_model_inst.wr(CH5_UPPER_LIMIT_LSB_AND_DEADBAND, 8'h51);
    wdw_host_model_inst.smp(3'h5, 12'h806, 2'b00);
    alert_chk(2'b11);
    wdw_host_model_inst.smp(3'h5, 12'h7fe, 2'b01);
    alert_chk(2'b11);
    wdw_host_model_inst.smp(3'h5, 12'h7fd, 2'b01);
    alert_chk(2'b10);
    wdw_host_model_inst.smp(3'h5, 12'h806, 2'b00);
    alert_chk(2'b10);
    // ----------------------------------------
    // reset in mid-run
    // ----------------------------------------
    @(negedge sys_clk_i);
    nrst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    alert_chk(2'b00);
    rd_chk(CH5_UPPER_LIMIT_MSB, UPPER_MSB_RST);
    rd_chk(CH5_UPPER_LIMIT_LSB_AND_DEADBAND, UPPER_LSB_DEADBAND_RST);
    rd_chk(CH6_UPPER_LIMIT_LSB_AND_DEADBAND, UPPER_LSB_DEADBAND_RST);
    rd_chk(CH5_LOWER_LIMIT_LSB_AND_TRIP_COUNT, LOWER_LSB_TRIP_RST);
    rd_chk(CH6_LOWER_LIMIT_MSB, LOWER_MSB_RST);
    complete_run();
  end
endmodule
